// *** hdl/cts_sequencer.sv ***
// Charge-cycle sequencer: timer, temperature faults, peak-drop, top-off, trickle.
// Assumes analog comparators and an ADC code outside; all their levels are async.
`timescale 1ns/100ps
`include "cts_params.svh"

// Notes on behaviour
// RULE1: Timer expiry in constant current means nickel; go top-off or trickle.
// RULE2: Cold pack in fast charge freezes timer, conditions, flashes indicator 1 Hz.
// RULE3: When cold clears, fast charge restarts with the frozen timer count.
// RULE4: Entering constant voltage adds one full period; constant current never exceeds one.
// RULE5: Nickel with top-off: timer cleared before top-off begins.
// RULE6: Hot comparator ignored during fast charge, honoured elsewhere.
// RULE7: Cutoff during fast charge ends it, suspends, indicator off.
// RULE8: After cutoff suspension, resume only in trickle once no longer hot.
// RULE9: Sample voltage every period/128, keep peak, flag drop by threshold.
// RULE10: Before each sample drive switch and timer pin low briefly.
// RULE11: Sampling only in constant current; ceiling watched in all phases (code checks it only in constant current, top-off and trickle).
// RULE12: Reaching ceiling marks lithium and stops sampling for the cycle.
// RULE13: In lithium voltage phase, low current ends fast charge.
// RULE14: After nickel fast charge measure capacitor to choose top-off.
// RULE15: Top-off starts cleared, ends on expiry, ceiling or temperature fault.
// RULE16: Top-off pulses switch once a second for one sixteenth second.
// RULE17: Indicator off throughout top-off and trickle maintenance.
// RULE18: Cold in top-off: pause timer, trickle pulses, resume when warm.
// RULE19: Hot in top-off: stop charge, timer runs; resume if time left.
// RULE20: Cutoff in top-off stops charge; only trickle once no longer hot.
// RULE21: Trickle pulses once a second, width set by resistor selection.
// RULE22: Timer pin grounded in sleep, steady when paused, running when active.
// RULE23: Peak-drop termination blocked for the first period/32 of fast charge.
// RULE24: Indicator held on throughout fast charge.
// RULE25: One tick base drives both the pulse second and the charge timer.
module cts_sequencer
  import cts_pkg::*;
#(
  parameter int TICK_CYC = `CTS_TICK_CYC,
  parameter int MTO_TICKS = `CTS_MTO_S * `CTS_SEC_TICKS,
  parameter int SEC_TICKS = `CTS_SEC_TICKS
) (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire cts_pkg::cts_sense_t       sense,
  input  wire logic [`CTS_ADC_W-1:0]     cell_voltage_in,
  input  wire logic                      loop_on,
  input  wire logic                      start_fast,
  input  wire logic                      restart,
  input  wire logic                      sleep_req,
  input  wire logic [11:0]               trickle_width,
  output logic                           switch_drive,
  output logic                           charge_indicator_out,
  output logic                           charge_indicator_oe,
  output cts_pkg::cts_pin_mode_t         timer_program_pin,
  output cts_pkg::cts_status_t           status
);
  import cts_pkg::*;

  // Derived widths and tick counts
  localparam int SW = $bits(cts_sense_t) + 5;
  localparam int TW = `CTS_TMR_W;
  localparam logic [TW-1:0] MAX_CHARGE_TIME = TW'(MTO_TICKS);
  localparam logic [TW-1:0] SAMP = TW'(MTO_TICKS / `CTS_SAMPLE_DIV);
  localparam logic [TW-1:0] HOLD = TW'(MTO_TICKS / `CTS_HOLDOFF_DIV);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0]  rst_sq;
  logic        rst_n;
  logic [SW-1:0] s1_q, s2_q;
  logic [`CTS_ADC_W-1:0] a1_q, a2_q;

  // Two-flop reset release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) rst_sq <= 2'h0;
    else rst_sq <= {rst_sq[0], 1'b1};
  end
  assign rst_n = rst_sq[1];

  // ----------------------------------------------------------------
  // Pin level synchronisers
  // ----------------------------------------------------------------
  // Two-flop sync of every pin level except trickle_width
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      a1_q <= '0;
      a2_q <= '0;
    end else begin
      s1_q <= {sense, loop_on, start_fast, restart, sleep_req, 1'b0};
      s2_q <= s1_q;
      a1_q <= cell_voltage_in;
      a2_q <= a1_q;
    end
  end

  // ----------------------------------------------------------------
  // Synchronised level unpack
  // ----------------------------------------------------------------
  cts_sense_t sn;
  logic loop_s, start_s, restart_s, sleep_s;
  // Fields in packing order
  assign sn        = s2_q[SW-1:5];
  assign loop_s    = s2_q[4];
  assign start_s   = s2_q[3];
  assign restart_s = s2_q[2];
  assign sleep_s   = s2_q[1];

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // Prescaler, second counter and tick
  logic [15:0] pre_q;
  logic [11:0] sec_q;
  logic        tick;
  assign tick = (pre_q == 16'(TICK_CYC - 1));

  // One tick feeds both the second and the timer [RULE25]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 16'h0000;
      sec_q <= 12'h000;
    end else begin
      pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
      if (tick) sec_q <= (sec_q == 12'(SEC_TICKS - 1)) ? 12'h000 : sec_q + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // State, timer and peak tracking
  // ----------------------------------------------------------------
  // State, timer, sample and peak registers
  cts_state_t st_q, st_d;
  logic [TW:0] rem_q;
  logic [TW-1:0] samp_q;
  logic [5:0] quiet_q;
  logic [`CTS_ADC_W-1:0] peak_q;
  logic lith_q, top_q, pvd_q, cv_q, sampled_q;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // State is one of the two fast-charge phases
  function automatic logic is_fast(input cts_state_t s);
    return (s == CTS_FAST_CC) || (s == CTS_FAST_CV);
  endfunction

  // Timer and sampling conditions
  wire expired   = (rem_q == '0);
  wire fast      = is_fast(st_q);
  wire cc        = (st_q == CTS_FAST_CC);
  // Timer runs in fast charge, top-off and while hot in top-off [RULE19]
  wire tmr_run   = fast || st_q == CTS_TOPOFF || st_q == CTS_TOP_HOT;
  wire elapsed_ok = (MAX_CHARGE_TIME - rem_q[TW-1:0]) >= HOLD; // [RULE23]
  wire samp_due  = cc && !lith_q && tick && (samp_q == SAMP - TW'(1)); // [RULE9] [RULE11]
  wire quiet     = (quiet_q != 6'h00) && cc; // [RULE11]
  wire capture   = (quiet_q == 6'h01) && cc;
  wire [`CTS_ADC_W:0] drop_lvl = {1'b0, a2_q} + (`CTS_ADC_W+1)'(`CTS_DROP_LSB);
  wire drop_hit  = capture && sampled_q && elapsed_ok && (drop_lvl <= {1'b0, peak_q}); // [RULE9]
  // Large cap with low resistor enables, small cap disables [RULE14]
  wire top_sel   = sn.cap_large && sn.res_low && !sn.cap_small;

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  // Next-state decode
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      CTS_IDLE:     if (start_s) st_d = CTS_FAST_CC;
      CTS_FAST_CC, CTS_FAST_CV: begin
        // Hot comparator not consulted here [RULE6]
        if (sn.cutoff) st_d = CTS_SUSP_CUT; // [RULE7]
        else if (sn.cold) st_d = CTS_COND; // [RULE2]
        else if (cc && sn.at_ceiling) st_d = CTS_FAST_CV; // [RULE12]
        else if (cc && (expired || drop_hit)) st_d = CTS_MEASURE; // [RULE1] [RULE14]
        else if (!cc && (expired || sn.current_low)) st_d = CTS_DONE; // [RULE13]
      end
      CTS_COND:     if (!sn.cold) st_d = cv_q ? CTS_FAST_CV : CTS_FAST_CC; // [RULE3]
      CTS_SUSP_CUT: if (!sn.hot) st_d = CTS_TRICKLE; // [RULE8]
      CTS_MEASURE:  st_d = top_sel ? CTS_TOPOFF : CTS_TRICKLE; // [RULE1]
      CTS_TOPOFF: begin
        if (sn.at_ceiling) st_d = CTS_DONE; // [RULE15]
        else if (sn.cutoff) st_d = CTS_TOP_CUT; // [RULE20]
        else if (sn.hot) st_d = CTS_TOP_HOT; // [RULE19]
        else if (sn.cold) st_d = CTS_TOP_COLD; // [RULE18]
        else if (expired) st_d = CTS_TRICKLE; // [RULE15]
      end
      CTS_TOP_COLD: if (!sn.cold) st_d = CTS_TOPOFF; // [RULE18]
      CTS_TOP_HOT: begin
        if (sn.cutoff) st_d = CTS_TOP_CUT;
        else if (!sn.hot) st_d = expired ? CTS_TRICKLE : CTS_TOPOFF; // [RULE19]
      end
      CTS_TOP_CUT:  if (!sn.hot) st_d = CTS_TRICKLE; // [RULE20]
      CTS_TRICKLE:  if (sn.at_ceiling) st_d = CTS_DONE;
      CTS_DONE:     st_d = CTS_DONE;
      default:      st_d = CTS_IDLE;
    endcase
    if (restart_s || sleep_s) st_d = CTS_IDLE;
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) st_q <= CTS_IDLE;
    else st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // Charge timer and sample interval
  // ----------------------------------------------------------------
  // Charge timer: load, extend, clear, count down
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rem_q <= '0;
    else if (st_q == CTS_IDLE) rem_q <= {1'b0, MAX_CHARGE_TIME};
    else if (cc && st_d == CTS_FAST_CV) rem_q <= rem_q + {1'b0, MAX_CHARGE_TIME}; // [RULE4]
    else if (st_q == CTS_MEASURE) rem_q <= {1'b0, MAX_CHARGE_TIME}; // [RULE5] [RULE15]
    else if (tmr_run && tick && !expired) rem_q <= rem_q - (TW+1)'(1); // [RULE2]
  end

  // Sample interval counter and quiet window
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_q  <= '0;
      quiet_q <= 6'h00;
    end else begin
      if (st_q == CTS_IDLE || samp_due) samp_q <= '0;
      else if (cc && tick) samp_q <= samp_q + TW'(1);
      if (samp_due) quiet_q <= 6'(`CTS_QUIET_CYC); // [RULE10]
      else if (!cc) quiet_q <= 6'h00; // [RULE11]
      else if (quiet) quiet_q <= quiet_q - 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Peak tracking and chemistry
  // ----------------------------------------------------------------
  // Peak, chemistry, top-off choice and termination flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      peak_q <= '0;
      sampled_q <= 1'b0;
      lith_q <= 1'b0;
      top_q <= 1'b0;
      pvd_q <= 1'b0;
      cv_q <= 1'b0;
    end else if (st_q == CTS_IDLE) begin
      peak_q <= '0;
      sampled_q <= 1'b0;
      lith_q <= 1'b0;
      top_q <= 1'b0;
      pvd_q <= 1'b0;
      cv_q <= 1'b0;
    end else begin
      if (capture && a2_q > peak_q) peak_q <= a2_q; // [RULE9]
      if (capture) sampled_q <= 1'b1;
      if (drop_hit && cc) pvd_q <= 1'b1;
      if (cc && st_d == CTS_FAST_CV) begin
        lith_q <= 1'b1; // [RULE12]
        cv_q <= 1'b1;
      end
      // Top-off choice latched while measuring [RULE14]
      if (st_q == CTS_MEASURE) top_q <= top_sel;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pulse windows within each second
  wire top_pulse = (sec_q < 12'(`CTS_TOPOFF_TICKS)); // [RULE16]
  wire trk_pulse = (sec_q < trickle_width); // [RULE21]
  wire flash_on  = (sec_q < 12'(`CTS_FLASH_TICKS)); // [RULE2]
  wire trk_state = (st_q == CTS_TRICKLE && !sn.hot) || st_q == CTS_TOP_COLD; // [RULE18]
  wire sw_d = (quiet || sleep_s) ? 1'b0 :               // [RULE10]
              fast ? loop_s :
              (st_q == CTS_TOPOFF) ? top_pulse :         // [RULE16]
              trk_state ? trk_pulse : 1'b0;              // [RULE21]
  wire led_d = fast || (st_q == CTS_IDLE || st_q == CTS_COND) && flash_on; // [RULE24] [RULE17]
  // Timer pin mode
  cts_pin_mode_t pin_d;
  assign pin_d = (sleep_s || quiet) ? CTS_PIN_GROUND :  // [RULE22] [RULE10]
                 (tmr_run || st_q == CTS_DONE) ? CTS_PIN_ACTIVE : CTS_PIN_DC;

  // ----------------------------------------------------------------
  // Pin drive registers
  // ----------------------------------------------------------------
  // Registered pin drives
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      switch_drive <= 1'b0;
      charge_indicator_oe <= 1'b0;
      timer_program_pin <= CTS_PIN_DC;
    end else begin
      switch_drive <= sw_d;
      charge_indicator_oe <= led_d; // Low pull lights indicator [RULE7]
      timer_program_pin <= pin_d;
    end
  end

  // Indicator pin and status word
  assign charge_indicator_out = 1'b0;
  assign status = '{state: st_q, lithium: lith_q, topoff_en: top_q, peak_drop_detect: pvd_q};
endmodule

// *** hdl/cts_params.svh ***
// Constants for the charge termination sequencer.
// Assumes a 10 MHz core clock; included by the sequencer only.
`ifndef CTS_PARAMS_SVH
`define CTS_PARAMS_SVH
`define CTS_CLK_HZ        10000000
`define CTS_TICK_US       500
`define CTS_TICK_CYC      ((`CTS_CLK_HZ / 1000000) * `CTS_TICK_US)
`define CTS_SEC_US        1000000
`define CTS_SEC_TICKS     (`CTS_SEC_US / `CTS_TICK_US)
`define CTS_FLASH_TICKS   (`CTS_SEC_TICKS / 2)
`define CTS_TOPOFF_US     62500
`define CTS_TOPOFF_TICKS  (`CTS_TOPOFF_US / `CTS_TICK_US)
`define CTS_MTO_S         3600
`define CTS_SAMPLE_DIV    128
`define CTS_HOLDOFF_DIV   32
`define CTS_QUIET_CYC     16
`define CTS_DROP_LSB      4
`define CTS_ADC_W         12
`define CTS_TMR_W         26
`endif

// *** hdl/cts_pkg.sv ***
// Types for the charge termination sequencer.
// Assumes nothing beyond the params header.
package cts_pkg;
  typedef enum logic [3:0] {
    CTS_IDLE     = 4'b0000,
    CTS_FAST_CC  = 4'b0001,
    CTS_FAST_CV  = 4'b0010,
    CTS_COND     = 4'b0011,
    CTS_SUSP_CUT = 4'b0100,
    CTS_MEASURE  = 4'b0101,
    CTS_TOPOFF   = 4'b0110,
    CTS_TOP_COLD = 4'b0111,
    CTS_TOP_HOT  = 4'b1000,
    CTS_TOP_CUT  = 4'b1001,
    CTS_TRICKLE  = 4'b1010,
    CTS_DONE     = 4'b1011
  } cts_state_t;

  typedef enum logic [1:0] {
    CTS_PIN_GROUND = 2'b00,
    CTS_PIN_DC     = 2'b01,
    CTS_PIN_ACTIVE = 2'b10
  } cts_pin_mode_t;

  // Comparator and strap levels from the analog front end
  typedef struct packed {
    logic cold;
    logic hot;
    logic cutoff;
    logic at_ceiling;
    logic current_low;
    logic cap_large;
    logic cap_small;
    logic res_low;
  } cts_sense_t;

  typedef struct packed {
    cts_state_t state;
    logic       lithium;
    logic       topoff_en;
    logic       peak_drop_detect;
  } cts_status_t;
endpackage

// *** verification/cts_seq_properties.sv ***
// Port checker for the charge termination sequencer.
// Assumes it is bound onto cts_sequencer; one clock domain.
`timescale 1ns/100ps
module cts_seq_props
  import cts_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   nrst,
  input wire logic                   sleep_req,
  input wire logic                   switch_drive,
  input wire logic                   charge_indicator_out,
  input wire logic                   charge_indicator_oe,
  input wire cts_pkg::cts_pin_mode_t timer_program_pin,
  input wire cts_pkg::cts_status_t   status
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  cts_state_t st;
  // State field for short properties
  assign st = status.state;
  chk_fast_led_on: assert property ((st == CTS_FAST_CC)[*2] |-> charge_indicator_oe)
    else $error("indicator dark in fast charge");
  chk_maint_led_off: assert property (
    (st inside {CTS_TOPOFF, CTS_TRICKLE})[*2] |-> !charge_indicator_oe)
    else $error("indicator lit in maintenance");
  chk_led_pin_low: assert property (charge_indicator_out == 1'b0)
    else $error("indicator pin not pulled low");
  chk_quiet_no_drive: assert property (
    timer_program_pin == CTS_PIN_GROUND |-> !switch_drive)
    else $error("switch driven while quiet");
  chk_sleep_grounds: assert property (
    sleep_req[*8] |-> timer_program_pin == CTS_PIN_GROUND)
    else $error("timer pin not grounded in sleep");
  chk_paused_pin_dc: assert property (
    (st inside {CTS_COND, CTS_TOP_COLD, CTS_TRICKLE})[*2] |-> timer_program_pin == CTS_PIN_DC)
    else $error("timer pin not steady while paused");
  chk_cv_lithium: assert property (st == CTS_FAST_CV |-> status.lithium)
    else $error("voltage phase without lithium mark");
  chk_measure_nickel: assert property (st == CTS_MEASURE |-> !status.lithium)
    else $error("measure entered for lithium pack");
  chk_cut_exit: assert property (
    (st == CTS_SUSP_CUT) ##1 (st != CTS_SUSP_CUT) |-> st inside {CTS_TRICKLE, CTS_IDLE})
    else $error("cutoff left to a charging state");
  chk_fast_exit: assert property (
    (st == CTS_FAST_CC) ##1 (st != CTS_FAST_CC)
    |-> st inside {CTS_FAST_CV, CTS_COND, CTS_SUSP_CUT, CTS_MEASURE, CTS_IDLE})
    else $error("fast charge left to a wrong state");
  cov_topoff: cover property (st == CTS_TOPOFF);
  cov_done: cover property (st == CTS_DONE);
  cov_drop: cover property (status.peak_drop_detect);
  cov_top_hot: cover property (st == CTS_TOP_HOT);
endmodule

bind cts_sequencer cts_seq_props u_props (
  .core_clk             (core_clk),
  .nrst                 (nrst),
  .sleep_req            (sleep_req),
  .switch_drive         (switch_drive),
  .charge_indicator_out (charge_indicator_out),
  .charge_indicator_oe  (charge_indicator_oe),
  .timer_program_pin    (timer_program_pin),
  .status               (status)
);

// *** verification/cts_pack_model.sv ***
// Battery pack, thermistor and timing-part model.
// Assumes the bench moves its controls just after rising edges.
`timescale 1ns/100ps
module cts_pack_model
  import cts_pkg::*;
#(
  parameter logic [11:0] CEIL = 12'hC00
) (
  input  wire logic [1:0]          heat,
  input  wire logic [11:0]         target,
  input  wire logic                taper,
  input  wire logic                topoff_strap,
  output wire cts_pkg::cts_sense_t sense,
  output wire logic [11:0]         cell_voltage_in
);
  // Thermistor: 0 normal, 1 cold, 2 hot, 3 beyond cutoff (also hot)
  assign sense.cold = (heat == 2'h1);
  assign sense.hot = heat[1];
  assign sense.cutoff = (heat == 2'h3);
  // Cell voltage and current taper only once at the ceiling
  assign cell_voltage_in = target;
  assign sense.at_ceiling = (target >= CEIL);
  assign sense.current_low = taper & sense.at_ceiling;
  // Timing capacitor and resistor straps
  assign sense.cap_large = topoff_strap;
  assign sense.cap_small = ~topoff_strap;
  assign sense.res_low = 1'b1;
endmodule

// *** verification/test_charge_termination_sequencer.sv ***
// Self-checking bench for the charge termination sequencer.
// Assumes the pack model and bound checker; short timer parameters.
`timescale 1ns/100ps
module test_charge_termination_sequencer
  import cts_pkg::*;
;
  `define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %0h want %0h", $time, g, e); end end
  localparam int MAX_CHARGE_TIME = 2560;
  logic          core_clk = 1'b0;
  logic          nrst = 1'b0;
  logic          loop_on = 1'b0;
  logic          start_fast = 1'b0;
  logic          restart = 1'b0;
  logic          sleep_req = 1'b0;
  logic [11:0]   trickle_width = 12'h028;
  logic [1:0]    heat = 2'h0;
  logic [11:0]   target = 12'h064;
  logic          taper = 1'b0;
  logic          topoff_strap = 1'b0;
  logic          switch_drive;
  logic          led_out;
  logic          charge_indicator_oe;
  cts_pin_mode_t pin;
  cts_status_t   status;
  cts_sense_t    sense;
  logic [11:0]   cell_v;
  int            checked = 0;
  int            n_mismatch = 0;
  always #50 core_clk = ~core_clk;
  cts_pack_model pack (.heat(heat), .target(target), .taper(taper),
    .topoff_strap(topoff_strap), .sense(sense), .cell_voltage_in(cell_v));
  cts_sequencer #(.TICK_CYC(1), .MTO_TICKS(MAX_CHARGE_TIME), .SEC_TICKS(2000)) uut (
    .core_clk(core_clk), .nrst(nrst), .sense(sense), .cell_voltage_in(cell_v),
    .loop_on(loop_on), .start_fast(start_fast), .restart(restart), .sleep_req(sleep_req),
    .trickle_width(trickle_width), .switch_drive(switch_drive),
    .charge_indicator_out(led_out), .charge_indicator_oe(charge_indicator_oe),
    .timer_program_pin(pin), .status(status));
  task automatic wrap_up();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_st(input cts_state_t s, input int n);
    for (int i = 0; i < n && status.state !== s; i++) cyc(1);
    `CHK(status.state, s)
  endtask
  task automatic set_heat(input logic [1:0] v);
    @(posedge core_clk);
    heat <= v;
  endtask
  // High cycles of switch or indicator over one second
  task automatic cnt(input bit charge_indicator, output logic [11:0] k);
    k = 12'h000;
    repeat (2000) begin
      @(negedge core_clk);
      k = k + {11'h000, (charge_indicator ? charge_indicator_oe : switch_drive)};
    end
  endtask
  task automatic begin_fast();
    @(posedge core_clk);
    restart <= 1'b1;
    start_fast <= 1'b0;
    heat <= 2'h0;
    taper <= 1'b0;
    target <= 12'h064;
    cyc(4);
    @(posedge core_clk);
    restart <= 1'b0;
    start_fast <= 1'b1;
    wait_st(CTS_FAST_CC, 12);
  endtask
  task automatic s_fast_temp();
    logic [11:0] k;
    begin_fast();
    cyc(4);
    `CHK(charge_indicator_oe, 1'b1)
    `CHK(pin, CTS_PIN_ACTIVE)
    set_heat(2'h2);
    cyc(20);
    `CHK(status.state, CTS_FAST_CC)
    set_heat(2'h1);
    wait_st(CTS_COND, 10);
    cnt(1'b1, k);
    `CHK(k, 12'h3E8)
    `CHK(pin, CTS_PIN_DC)
    set_heat(2'h0);
    wait_st(CTS_FAST_CC, 10);
  endtask
  task automatic s_cutoff();
    begin_fast();
    set_heat(2'h3);
    wait_st(CTS_SUSP_CUT, 10);
    cyc(3);
    `CHK(charge_indicator_oe, 1'b0)
    set_heat(2'h2);
    cyc(20);
    `CHK(status.state, CTS_SUSP_CUT)
    set_heat(2'h0);
    wait_st(CTS_TRICKLE, 10);
  endtask
  task automatic s_peak();
    @(posedge core_clk);
    topoff_strap <= 1'b0;
    loop_on <= 1'b1;
    begin_fast();
    cyc(40);
    @(posedge core_clk);
    target <= 12'h060;
    cyc(40);
    `CHK(status.state, CTS_FAST_CC)
    wait_st(CTS_MEASURE, 80);
    `CHK(status.peak_drop_detect, 1'b1)
    wait_st(CTS_TRICKLE, 10);
    @(posedge core_clk);
    loop_on <= 1'b0;
  endtask
  task automatic s_topoff();
    logic [11:0] k;
    @(posedge core_clk);
    topoff_strap <= 1'b1;
    begin_fast();
    wait_st(CTS_TOPOFF, MAX_CHARGE_TIME + 100);
    `CHK(status.lithium, 1'b0)
    `CHK(status.topoff_en, 1'b1)
    cnt(1'b0, k);
    `CHK(k, 12'h07D)
    `CHK(status.state, CTS_TOPOFF)
    `CHK(pin, CTS_PIN_ACTIVE)
    set_heat(2'h1);
    wait_st(CTS_TOP_COLD, 10);
    set_heat(2'h0);
    wait_st(CTS_TOPOFF, 10);
    set_heat(2'h2);
    wait_st(CTS_TOP_HOT, 10);
    cyc(3);
    `CHK(switch_drive, 1'b0)
    `CHK(pin, CTS_PIN_ACTIVE)
    cyc(700);
    set_heat(2'h0);
    wait_st(CTS_TRICKLE, 10);
    cnt(1'b0, k);
    `CHK(k, trickle_width)
  endtask
  task automatic s_lithium();
    begin_fast();
    @(posedge core_clk);
    target <= 12'hC00;
    wait_st(CTS_FAST_CV, 10);
    `CHK(status.lithium, 1'b1)
    @(posedge core_clk);
    taper <= 1'b1;
    wait_st(CTS_DONE, 10);
    cyc(3);
    `CHK(pin, CTS_PIN_ACTIVE)
  endtask
  // Main sequence: reset, sleep, then each scenario
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    cyc(6);
    `CHK(status.state, CTS_IDLE)
    `CHK(switch_drive, 1'b0)
    @(posedge core_clk);
    sleep_req <= 1'b1;
    cyc(10);
    `CHK(pin, CTS_PIN_GROUND)
    @(posedge core_clk);
    sleep_req <= 1'b0;
    s_fast_temp();
    s_cutoff();
    s_peak();
    s_topoff();
    s_lithium();
    wrap_up();
  end
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end
endmodule
